// ==== hdl/ustp_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module ustp_port
  import ustp_pkg::*;
(
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  // controller side
  input wire logic [1:0] i_mode,
  input wire logic i_tx_req,
  input wire ustp_line_s i_tx_line,
  output var ustp_line_s o_rx_line,
  output logic o_rx_valid,
  // transceiver pins
  output logic o_tx_enable_n,
  input wire logic i_data_plus_pin,
  output logic o_data_plus_pin,
  output logic o_data_plus_pin_oe,
  input wire logic i_single_ended_zero_minus_pin,
  output logic o_single_ended_zero_minus_pin,
  output logic o_single_ended_zero_minus_pin_oe,
  input wire logic i_rx_plus_input,
  input wire logic i_rx_minus_input
);

  ustp_mode_e mode;
  logic tx_enable_n;
  logic pin_a;
  logic pin_b;
  logic next_pin_a;
  logic next_pin_b;
  logic bidir;
  ustp_line_s next_rx;

  // mode only changes between packets; a switch mid-packet would glitch the pins
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      mode <= ustp_mode_e'(USTP_MODE_RESET);
    end else if (i_ce && tx_enable_n && !i_tx_req) begin
      mode <= ustp_mode_e'(i_mode);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tx_enable_n <= USTP_TX_ENABLE_N_RESET;
    end else if (i_ce) begin
      tx_enable_n <= !i_tx_req;
    end
  end

  always_comb begin
    next_pin_a = 1'b0;
    next_pin_b = 1'b0;
    unique case (mode)
      USTP_DZ_BIDIR, USTP_DZ_UNIDIR: begin
        next_pin_a = i_tx_line.data & !i_tx_line.se0;
        next_pin_b = i_tx_line.se0;
      end
      USTP_PM_BIDIR, USTP_PM_UNIDIR: begin
        next_pin_a = i_tx_line.plus;
        next_pin_b = i_tx_line.minus;
      end
    endcase
  end

  // pin data registered with the enable so both change on the same edge
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pin_a <= 1'b0;
      pin_b <= 1'b0;
    end else if (i_ce) begin
      pin_a <= i_tx_req ? next_pin_a : 1'b0;
      pin_b <= i_tx_req ? next_pin_b : 1'b0;
    end
  end

  assign bidir = (mode == USTP_DZ_BIDIR) || (mode == USTP_PM_BIDIR);
  assign o_tx_enable_n = tx_enable_n;
  assign o_data_plus_pin = pin_a;
  assign o_single_ended_zero_minus_pin = pin_b;
  // unidirectional pins stay driven; bidirectional ones are released for receive
  assign o_data_plus_pin_oe = !bidir || !tx_enable_n;
  assign o_single_ended_zero_minus_pin_oe = !bidir || !tx_enable_n;

  always_comb begin
    next_rx = USTP_LINE_RESET;
    unique case (mode)
      USTP_DZ_BIDIR: begin
        next_rx.data = i_data_plus_pin;
        next_rx.se0 = i_single_ended_zero_minus_pin;
      end
      USTP_DZ_UNIDIR: begin
        next_rx.plus = i_rx_plus_input;
        next_rx.minus = i_rx_minus_input;
        next_rx.se0 = !i_rx_plus_input && !i_rx_minus_input;
        next_rx.data = i_rx_plus_input;
      end
      USTP_PM_BIDIR: begin
        next_rx.plus = i_data_plus_pin;
        next_rx.minus = i_single_ended_zero_minus_pin;
      end
      USTP_PM_UNIDIR: begin
        next_rx.plus = i_rx_plus_input;
        next_rx.minus = i_rx_minus_input;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_rx_line <= USTP_LINE_RESET;
      o_rx_valid <= 1'b0;
    end else if (i_ce) begin
      o_rx_line <= tx_enable_n ? next_rx : USTP_LINE_RESET;
      o_rx_valid <= tx_enable_n;
    end
  end

  a_txen_follows_req: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce |=> o_tx_enable_n == !$past(i_tx_req)) else $error("tx enable wrong");
  a_bidir_release: assert property (@(posedge i_mclk) disable iff (i_srst)
    (bidir && o_tx_enable_n) |-> !o_data_plus_pin_oe && !o_single_ended_zero_minus_pin_oe)
    else $error("bidir pins not released");
  a_drive_on_tx: assert property (@(posedge i_mclk) disable iff (i_srst)
    !o_tx_enable_n |-> o_data_plus_pin_oe && o_single_ended_zero_minus_pin_oe)
    else $error("pins not driven in tx");
  a_unidir_driven: assert property (@(posedge i_mclk) disable iff (i_srst)
    !bidir |-> o_data_plus_pin_oe) else $error("unidir pin released");
  a_se0_override: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && i_tx_req && i_tx_line.se0 && mode inside {USTP_DZ_BIDIR, USTP_DZ_UNIDIR})
    |=> !o_data_plus_pin && o_single_ended_zero_minus_pin) else $error("se0 not forced");
  a_dz_data_out: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && i_tx_req && !i_tx_line.se0 && mode == USTP_DZ_BIDIR)
    |=> o_data_plus_pin == $past(i_tx_line.data)) else $error("data pin wrong");
  a_pm_out: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && i_tx_req && mode inside {USTP_PM_BIDIR, USTP_PM_UNIDIR})
    |=> o_single_ended_zero_minus_pin == $past(i_tx_line.minus)) else $error("minus wrong");
  a_pm_uni_rx: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && tx_enable_n && mode == USTP_PM_UNIDIR)
    |=> o_rx_line.plus == $past(i_rx_plus_input) && o_rx_valid) else $error("rx plus wrong");
  a_mode_stable_tx: assert property (@(posedge i_mclk) disable iff (i_srst)
    !o_tx_enable_n |=> $stable(mode)) else $error("mode changed in tx");

  // steps shared by the checks below
  sequence s_tx_taken;
    i_ce && i_tx_req;
  endsequence

  sequence s_rx_taken;
    i_ce && tx_enable_n;
  endsequence

  sequence s_frozen;
    !i_ce;
  endsequence

  // a low enable must freeze every register, pins included
  a_txen_frozen: assert property (@(posedge i_mclk) disable iff (i_srst)
    s_frozen
    |=> $stable(o_tx_enable_n))
    else $error("tx enable moved while frozen");

  a_pins_frozen: assert property (@(posedge i_mclk) disable iff (i_srst)
    s_frozen
    |=> $stable(o_data_plus_pin) && $stable(o_single_ended_zero_minus_pin))
    else $error("pins moved while frozen");

  a_rx_frozen: assert property (@(posedge i_mclk) disable iff (i_srst)
    s_frozen
    |=> $stable(o_rx_line) && $stable(o_rx_valid))
    else $error("receive moved while frozen");

  a_rx_quiet_tx: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && !tx_enable_n)
    |=> !o_rx_valid && o_rx_line == USTP_LINE_RESET)
    else $error("receive valid during tx");

  a_dz_bidir_rx: assert property (@(posedge i_mclk) disable iff (i_srst)
    s_rx_taken ##0 (mode == USTP_DZ_BIDIR)
    |=> o_rx_line.data == $past(i_data_plus_pin)
      && o_rx_line.se0 == $past(i_single_ended_zero_minus_pin))
    else $error("dz bidir receive wrong");

  a_dz_uni_rx: assert property (@(posedge i_mclk) disable iff (i_srst)
    s_rx_taken ##0 (mode == USTP_DZ_UNIDIR)
    |=> o_rx_line.plus == $past(i_rx_plus_input)
      && o_rx_line.se0 == (!$past(i_rx_plus_input) && !$past(i_rx_minus_input)))
    else $error("dz unidir receive wrong");

  a_pm_bidir_rx: assert property (@(posedge i_mclk) disable iff (i_srst)
    s_rx_taken ##0 (mode == USTP_PM_BIDIR)
    |=> o_rx_line.plus == $past(i_data_plus_pin)
      && o_rx_line.minus == $past(i_single_ended_zero_minus_pin))
    else $error("pm bidir receive wrong");

  a_pm_plus_out: assert property (@(posedge i_mclk) disable iff (i_srst)
    s_tx_taken ##0 (mode inside {USTP_PM_BIDIR, USTP_PM_UNIDIR})
    |=> o_data_plus_pin == $past(i_tx_line.plus))
    else $error("plus pin wrong");

  a_dz_se0_out: assert property (@(posedge i_mclk) disable iff (i_srst)
    s_tx_taken ##0 (mode == USTP_DZ_BIDIR)
    |=> o_single_ended_zero_minus_pin == $past(i_tx_line.se0))
    else $error("se0 pin wrong");

  // idle pins rest low so a unidirectional transceiver sees no stray state
  a_idle_pins_low: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && !i_tx_req)
    |=> !o_data_plus_pin && !o_single_ended_zero_minus_pin)
    else $error("idle pins not low");

  a_mode_held_req: assert property (@(posedge i_mclk) disable iff (i_srst)
    s_tx_taken
    |=> $stable(mode))
    else $error("mode changed under request");

endmodule
`default_nettype wire

// ==== hdl/ustp_pkg.sv ====
package ustp_pkg;

  // wiring mode select
  typedef enum logic [1:0] {
    USTP_DZ_BIDIR,
    USTP_DZ_UNIDIR,
    USTP_PM_BIDIR,
    USTP_PM_UNIDIR
  } ustp_mode_e;

  // line state as seen or requested by the controller
  typedef struct packed {
    logic plus;
    logic minus;
    logic data;
    logic se0;
  } ustp_line_s;

  localparam logic [1:0] USTP_MODE_RESET = 2'h0;
  localparam logic USTP_TX_ENABLE_N_RESET = 1'h1;
  localparam ustp_line_s USTP_LINE_RESET = 4'h0;

endpackage

// ==== tb/ustp_xcvr_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ustp_xcvr_model (
  // controller pins
  input wire logic i_tx_enable_n,
  input wire logic [1:0] i_out,
  input wire logic [1:0] i_oe,
  // bench-chosen receive levels
  input wire logic [1:0] i_drive,
  // resolved levels
  output logic [1:0] o_pin,
  output logic [1:0] o_rx
);
  // lines show the inverse while transmitting, so a stale sample cannot pass
  logic [1:0] line;
  assign line = i_tx_enable_n ? i_drive : ~i_drive;
  assign o_pin = (i_oe & i_out) | (~i_oe & line);
  assign o_rx = line;
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("unexpected %0t mismatch %h %h", $time, a, b); end end
module testbench;
  import ustp_pkg::*;
  logic i_mclk = 0, i_srst = 1, i_tx_req = 0, i_ce = 1;
  logic [1:0] i_mode = 0, drv = 0, p_in, p_out, p_oe, rx_in;
  logic o_tx_enable_n, o_rx_valid;
  ustp_line_s i_tx_line = 0, o_rx_line;
  int errors = 0, comparisons = 0;
  // mode, tx line, pin a/b, rx a/b, rx line, rx mask
  logic [17:0] rows [4] = '{18'h0_3513, 18'h1_281F, 18'h2_994C, 18'h3_668C};
  initial forever #5 i_mclk = ~i_mclk;
  ustp_port ustp_port_i (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce), .i_mode(i_mode),
    .i_tx_req(i_tx_req), .i_tx_line(i_tx_line), .o_rx_line(o_rx_line),
    .o_rx_valid(o_rx_valid), .o_tx_enable_n(o_tx_enable_n),
    .i_data_plus_pin(p_in[1]), .o_data_plus_pin(p_out[1]), .o_data_plus_pin_oe(p_oe[1]),
    .i_single_ended_zero_minus_pin(p_in[0]), .o_single_ended_zero_minus_pin(p_out[0]),
    .o_single_ended_zero_minus_pin_oe(p_oe[0]),
    .i_rx_plus_input(rx_in[1]), .i_rx_minus_input(rx_in[0]));
  ustp_xcvr_model ustp_xcvr_model_i (.i_tx_enable_n(o_tx_enable_n), .i_out(p_out),
    .i_oe(p_oe), .i_drive(drv), .o_pin(p_in), .o_rx(rx_in));
  task automatic test_done();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_mclk);
    @(negedge i_mclk);
    i_srst = 0;
    `CHK(o_tx_enable_n, 1'b1)
    `CHK(o_rx_valid, 1'b0)
    `CHK(p_oe, 2'b00)
    // mode is only taken while idle, so it is set with the request low
    foreach (rows[k]) begin
      i_mode = rows[k][17:16];
      drv = rows[k][9:8];
      repeat (2) @(negedge i_mclk);
      i_tx_req = 1;
      i_tx_line = rows[k][15:12];
      @(negedge i_mclk);
      `CHK(o_tx_enable_n, 1'b0)
      `CHK(p_out, rows[k][11:10])
      `CHK(p_oe, 2'b11)
      i_tx_req = 0;
      repeat (3) @(negedge i_mclk);
      `CHK(o_tx_enable_n, 1'b1)
      `CHK(o_rx_valid, 1'b1)
      `CHK(o_rx_line & rows[k][3:0], rows[k][7:4])
      `CHK(p_oe, {2{i_mode[0]}})
    end
    // mode change raised together with the transmit request is held off
    i_tx_req = 1;
    i_mode = 0;
    i_tx_line = 4'h3;
    repeat (2) @(negedge i_mclk);
    `CHK(p_out, 2'b00)
    i_tx_req = 0;
    repeat (2) @(negedge i_mclk);
    // a low enable holds the request off; nothing may move
    i_ce = 0;
    i_tx_req = 1;
    i_tx_line = 4'h2;
    repeat (2) @(negedge i_mclk);
    `CHK(o_tx_enable_n, 1'b1)
    `CHK(p_out, 2'b00)
    i_ce = 1;
    @(negedge i_mclk);
    `CHK(o_tx_enable_n, 1'b0)
    `CHK(p_out, 2'b10)
    // reset in mid-transmit drops the pins and hands the lines back
    i_srst = 1;
    @(negedge i_mclk);
    `CHK(o_tx_enable_n, 1'b1)
    `CHK(p_out, 2'b00)
    `CHK(p_oe, 2'b00)
    `CHK(o_rx_valid, 1'b0)
    i_srst = 0;
    @(negedge i_mclk);
    `CHK(o_tx_enable_n, 1'b0)
    `CHK(p_out, 2'b10)
    i_tx_req = 0;
    repeat (2) @(negedge i_mclk);
    test_done();
  end
endmodule
`default_nettype wire
